// *** design/cip_status_poll_unit.sv ***
// Notes on behaviour
// RQ1: Host writes command bit seven as zero.
// RQ2: Bits four-three 01 decode the read/poll command.
// RQ3: Enable bit picks special or normal masking.
// RQ4: Poll bit makes next read an acknowledge.
// RQ5: Poll byte top bit flags request present.
// RQ6: Poll byte low bits give winning level.
// RQ7: Low bits select pending or in-service reads.
// RQ8: Selected status register stays until rewritten.
// RQ9: Pending bits show unacknowledged requests per level.
// RQ10: In-service bits hold from acknowledge until end.
// RQ11: In-service blocks same and lower priority.
// RQ12: Higher priority still interrupts during service.
// RQ13: Each input selects edge or level sensing.
// RQ14: Reset leaves every input rising-edge sensitive; the code always senses primary level 2 (the cascade) as a level.
// RQ15: Zero means edge; inputs 0,1,2,8,13 fixed.
// RQ16: Bits four-three 00 decode priority/end command.
// RQ17: Host writes mask before other command words.
// RQ18: Masking primary level two blocks secondary.
// RQ19: Poll read sets service, clears pending, exits.
// RQ20: Special masking lets unmasked lower levels in.
`timescale 1ns/1ps
`default_nettype none
`include "cip_params.svh"
module cip_status_poll_unit import cip_pkg::*; (
  input wire logic CLK_SYS, // 10 MHz system clock
  input wire logic RST_N, // Asynchronous reset, active low
  input wire logic HSEL, // Slave select
  input wire logic [31:0] HADDR, // Byte address
  input wire logic [1:0] HTRANS, // Transfer type
  input wire logic HWRITE, // Write when high
  input wire logic [2:0] HSIZE, // Word transfers only
  input wire logic [31:0] HWDATA, // Write data
  input wire logic HREADY, // Bus ready
  output logic [31:0] HRDATA, // Read data, registered
  output logic HREADYOUT, // Low for one wait state on reads
  output logic HRESP, // Always OKAY
  input wire logic [15:0] IRQ_IN, // Request pins, levels 0..15
  output logic INT_OUT // Interrupt to the processor
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Fixed priority: level 0 wins; returns {valid, level}
  function automatic logic [3:0] enc(input logic [7:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) r = {1'b1, 3'(i)};
    end
    return r;
  endfunction

  // Bits strictly above the highest in-service priority
  function automatic logic [7:0] above(input logic [7:0] s);
    logic [7:0] lb;
    lb = s & (~s + 8'h01);
    return lb - 8'h01;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  logic [15:0] irq_m_q, irq_s_q;
  // Second stage is the only reader of the first
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      irq_m_q <= 16'h0000;
      irq_s_q <= 16'h0000;
    end else begin
      irq_m_q <= IRQ_IN;
      irq_s_q <= irq_m_q;
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  logic ph_v_q, ph_v_d, ph_w_q, ph_w_d, done_q, done_d;
  logic [7:0] ph_a_q, ph_a_d, rd_byte, wb;
  logic [31:0] hrdata_q, hrdata_d;
  logic acc, cap, wr_en;
  logic [1:0] wr_cmd, rd_cmd, wr_mask, wr_elv;
  logic [1:0] int_req;
  logic [1:0][7:0] poll_b, stat_b, mask_b, elv_b;
  logic int_q;

  assign acc = HSEL & HTRANS[1] & HREADY;
  // Read data is captured during one wait state so it leaves a flop
  assign cap = ph_v_q & ~ph_w_q & ~done_q;
  assign wr_en = ph_v_q & ph_w_q & HREADY;
  assign wb = HWDATA[7:0];
  assign HREADYOUT = ~cap;
  assign HRESP = 1'b0;
  assign HRDATA = hrdata_q;
  assign INT_OUT = int_q;

  // Strobes per controller
  always_comb begin
    wr_cmd[0] = wr_en & (ph_a_q == `CIP_A_PRI_CMD); // RQ2
    wr_cmd[1] = wr_en & (ph_a_q == `CIP_A_SEC_CMD); // RQ2
    rd_cmd[0] = cap & (ph_a_q == `CIP_A_PRI_CMD);
    rd_cmd[1] = cap & (ph_a_q == `CIP_A_SEC_CMD);
    wr_mask[0] = wr_en & (ph_a_q == `CIP_A_PRI_MASK);
    wr_mask[1] = wr_en & (ph_a_q == `CIP_A_SEC_MASK);
    wr_elv[0] = wr_en & (ph_a_q == `CIP_A_EDGE1);
    wr_elv[1] = wr_en & (ph_a_q == `CIP_A_EDGE2);
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_byte = 8'h00;
    unique case (ph_a_q)
      `CIP_A_PRI_CMD: rd_byte = ctl[0].poll_q ? poll_b[0] : stat_b[0]; // RQ4
      `CIP_A_SEC_CMD: rd_byte = ctl[1].poll_q ? poll_b[1] : stat_b[1]; // RQ4
      `CIP_A_PRI_MASK: rd_byte = mask_b[0];
      `CIP_A_SEC_MASK: rd_byte = mask_b[1];
      `CIP_A_EDGE1: rd_byte = elv_b[0];
      `CIP_A_EDGE2: rd_byte = elv_b[1];
      default: rd_byte = 8'h00;
    endcase
  end

  // Bus phase next state
  always_comb begin
    ph_v_d = ph_v_q;
    ph_w_d = ph_w_q;
    ph_a_d = ph_a_q;
    done_d = done_q;
    hrdata_d = hrdata_q;
    if (cap) begin
      hrdata_d = {24'h000000, rd_byte};
      done_d = 1'b1;
    end
    if (HREADY) begin
      ph_v_d = acc;
      ph_w_d = HWRITE;
      ph_a_d = HADDR[7:0];
      done_d = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ph_v_q <= 1'b0;
      ph_w_q <= 1'b0;
      ph_a_q <= 8'h00;
      done_q <= 1'b0;
      hrdata_q <= 32'h00000000;
      int_q <= 1'b0;
    end else begin
      ph_v_q <= ph_v_d;
      ph_w_q <= ph_w_d;
      ph_a_q <= ph_a_d;
      done_q <= done_d;
      hrdata_q <= hrdata_d;
      int_q <= int_req[0];
    end
  end

  // ----------------------------------------------------------------
  // Controllers: 0 primary, 1 secondary cascaded into level 2
  // ----------------------------------------------------------------
  for (genvar c = 0; c < 2; c++) begin : ctl
    logic [7:0] pend_q, pend_d, insv_q, insv_d, mask_q, mask_d;
    logic [7:0] elv_q, elv_d, prev_q, req, rise, lvl, elig, cand;
    logic spm_q, spm_d, poll_q, poll_d, ack;
    cip_rdsel_t sel_q, sel_d;
    logic [3:0] win;

    // Secondary request feeds primary level 2 as a level
    assign req = (c == 0) ? {irq_s_q[7:3], int_req[1], irq_s_q[1:0]}
                          : irq_s_q[15:8]; // RQ18
    assign rise = req & ~prev_q;
    assign lvl = elv_q | ((c == 0) ? `CIP_CASC_BIT : 8'h00); // RQ13
    assign elig = pend_q & ~mask_q; // RQ18
    // Special masking ignores priority of levels in service
    assign cand = spm_q ? (elig & ~insv_q) // RQ20
                        : (elig & above(insv_q)); // RQ11 RQ12
    assign win = enc(cand);
    assign ack = rd_cmd[c] & poll_q & win[3];
    assign int_req[c] = win[3];
    assign poll_b[c] = {win[3], 4'h0, win[2:0]}; // RQ5 RQ6
    assign stat_b[c] = (sel_q == CIP_SEL_INSV) ? insv_q : pend_q; // RQ8
    assign mask_b[c] = mask_q;
    assign elv_b[c] = elv_q;

    // Next state for one controller
    always_comb begin
      pend_d = pend_q;
      insv_d = insv_q;
      mask_d = mask_q;
      elv_d = elv_q;
      spm_d = spm_q;
      poll_d = poll_q;
      sel_d = sel_q;
      // New edge beats an acknowledge in the same cycle
      for (int i = 0; i < 8; i++) begin
        if (lvl[i]) begin
          pend_d[i] = req[i]; // RQ13
        end else begin
          pend_d[i] = rise[i] | (pend_q[i] &
                     ~(ack && (win[2:0] == 3'(i)))); // RQ9
        end
      end
      if (ack) begin
        insv_d[win[2:0]] = 1'b1; // RQ10 RQ19
      end
      if (rd_cmd[c] && poll_q) begin
        poll_d = 1'b0; // RQ19
      end
      if (wr_cmd[c]) begin
        if (wb[`CIP_SEL_MSB:`CIP_SEL_LSB] == `CIP_SEL_RDPOLL) begin // RQ2
          if (wb[`CIP_MASKCHG_BIT]) begin
            spm_d = wb[`CIP_SPMASK_BIT]; // RQ3
          end
          poll_d = wb[`CIP_POLL_BIT]; // RQ4
          if (wb[1:0] == `CIP_RD_PEND) begin
            sel_d = CIP_SEL_PEND; // RQ7
          end else if (wb[1:0] == `CIP_RD_INSV) begin
            sel_d = CIP_SEL_INSV; // RQ7
          end
        end else if (wb[`CIP_SEL_MSB:`CIP_SEL_LSB] == `CIP_SEL_PRIO) begin
          // RQ16
          if (wb[7:5] == `CIP_END_NONSPEC) begin
            insv_d = insv_q & ~(insv_q & (~insv_q + 8'h01)); // RQ10
          end else if (wb[7:5] == `CIP_END_SPEC) begin
            insv_d[wb[2:0]] = 1'b0; // RQ10
          end
        end
      end
      if (wr_mask[c]) begin
        mask_d = wb;
      end
      if (wr_elv[c]) begin
        elv_d = wb & ((c == 0) ? `CIP_EDGE_RW_PRI
                               : `CIP_EDGE_RW_SEC); // RQ15
      end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
        pend_q <= 8'h00;
        insv_q <= 8'h00;
        mask_q <= `CIP_MASK_RST;
        elv_q <= `CIP_EDGE_RST; // RQ14
        prev_q <= 8'h00;
        spm_q <= 1'b0;
        poll_q <= 1'b0;
        sel_q <= CIP_SEL_PEND;
      end else begin
        pend_q <= pend_d;
        insv_q <= insv_d;
        mask_q <= mask_d;
        elv_q <= elv_d;
        prev_q <= req;
        spm_q <= spm_d;
        poll_q <= poll_d;
        sel_q <= sel_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks on the primary controller and the secondary fixed edge bits
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  a_mask_mode_set: assert property (wr_cmd[0] && wb[4:3] == 2'h1
    && wb[5] |=> ctl[0].spm_q == $past(wb[6])) // RQ3
    else $error("mask mode not taken from command");
  a_mask_mode_hold: assert property (wr_cmd[0] && wb[4:3] == 2'h1
    && !wb[5] |=> $stable(ctl[0].spm_q)) // RQ3
    else $error("mask mode changed without enable");
  a_select_sticky: assert property (wr_cmd[0] && wb[4:3] == 2'h1
    && wb[1:0] == 2'h3 ##1 !wr_cmd[0] [*2] |-> ctl[0].sel_q
    == CIP_SEL_INSV) // RQ7 RQ8
    else $error("in-service selection lost");
  a_status_read: assert property (rd_cmd[0] && !ctl[0].poll_q
    && ctl[0].sel_q == CIP_SEL_PEND |=> HRDATA[7:0]
    == $past(ctl[0].pend_q) && HREADYOUT) // RQ8 RQ9
    else $error("pending read returned wrong byte");
  a_poll_response: assert property (rd_cmd[0] && ctl[0].poll_q
    |=> HRDATA[7] == $past(int_req[0]) && (!HRDATA[7]
    || HRDATA[2:0] == $past(ctl[0].win[2:0]))) // RQ5 RQ6
    else $error("poll byte wrong");
  a_poll_full_ack: assert property (ctl[0].ack |=> !ctl[0].poll_q
    && ctl[0].insv_q[$past(ctl[0].win[2:0])]) // RQ4 RQ19
    else $error("poll read did not acknowledge");
  a_eoi_not_read_poll_mask_command: assert property (wr_cmd[0] && wb[4:3] == 2'h0
    |=> $stable(ctl[0].spm_q) && $stable(ctl[0].sel_q)) // RQ16
    else $error("priority command changed read state");
  a_inhibit_lower: assert property (!ctl[0].spm_q
    && ctl[0].insv_q[0] |-> !int_req[0]) // RQ11
    else $error("request passed level in service");
  a_allow_higher: assert property (!ctl[0].spm_q
    && ctl[0].insv_q == 8'h80 && ctl[0].pend_q[0] && !ctl[0].mask_q[0]
    |-> int_req[0] ##1 INT_OUT) // RQ12
    else $error("higher request blocked");
  // Level 7 must itself be out of service to be eligible
  a_special_mask: assert property (ctl[0].spm_q && ctl[0].insv_q[0]
    && !ctl[0].insv_q[7] && ctl[0].pend_q[7] && !ctl[0].mask_q[7]
    |-> int_req[0]) // RQ20
    else $error("special mask blocked lower level");
  a_cascade_mask: assert property (ctl[0].mask_q[2]
    |-> !ctl[0].cand[2]) // RQ18
    else $error("masked cascade passed");
  a_edge_fixed: assert property (ctl[0].elv_q[2:0] == 3'h0
    && ctl[1].elv_q[0] == 1'b0 && ctl[1].elv_q[5] == 1'b0) // RQ15
    else $error("fixed edge bit set");
  c_poll_hit: cover property (ctl[0].ack);
  c_cascade_int: cover property (int_req[1] ##1 int_req[0]);
  c_nested: cover property (ctl[0].insv_q[3] && int_req[0]);
endmodule
`default_nettype wire

// *** design/cip_params.svh ***
`ifndef CIP_PARAMS_SVH
`define CIP_PARAMS_SVH
// ----------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------
`define CIP_OFF_CMD 8'h00
`define CIP_OFF_MASK 8'h01
`define CIP_OFF_EDGE1 8'h00
`define CIP_OFF_EDGE2 8'h01
`define CIP_BASE_PRI 8'h00
`define CIP_BASE_SEC 8'h08
`define CIP_BASE_EDGE 8'h10
`define CIP_A_PRI_CMD (`CIP_BASE_PRI + 8'h04 * `CIP_OFF_CMD)
`define CIP_A_PRI_MASK (`CIP_BASE_PRI + 8'h04 * `CIP_OFF_MASK)
`define CIP_A_SEC_CMD (`CIP_BASE_SEC + 8'h04 * `CIP_OFF_CMD)
`define CIP_A_SEC_MASK (`CIP_BASE_SEC + 8'h04 * `CIP_OFF_MASK)
`define CIP_A_EDGE1 (`CIP_BASE_EDGE + 8'h04 * `CIP_OFF_EDGE1)
`define CIP_A_EDGE2 (`CIP_BASE_EDGE + 8'h04 * `CIP_OFF_EDGE2)
// ----------------------------------------------------------------
// Command word fields
// ----------------------------------------------------------------
`define CIP_SEL_MSB 4
`define CIP_SEL_LSB 3
`define CIP_SEL_RDPOLL 2'h1
`define CIP_SEL_PRIO 2'h0
`define CIP_SPMASK_BIT 6
`define CIP_MASKCHG_BIT 5
`define CIP_POLL_BIT 2
`define CIP_RD_PEND 2'h2
`define CIP_RD_INSV 2'h3
`define CIP_END_NONSPEC 3'h1
`define CIP_END_SPEC 3'h3
`define CIP_PRES_BIT 7
// ----------------------------------------------------------------
// Reset values and fixed bits
// ----------------------------------------------------------------
`define CIP_MASK_RST 8'hFF
`define CIP_EDGE_RST 8'h00
`define CIP_EDGE_RW_PRI 8'hF8
`define CIP_EDGE_RW_SEC 8'hDE
`define CIP_CASC_BIT 8'h04
`endif

// *** design/cip_pkg.sv ***
// ----------------------------------------------------------------
// Shared types
// ----------------------------------------------------------------
package cip_pkg;
  typedef enum logic {
    CIP_SEL_PEND = 1'b0,
    CIP_SEL_INSV = 1'b1
  } cip_rdsel_t;
endpackage

// *** sim/cip_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Host core model: single-word bus master
// ----------------------------------------------------------------
module cip_host_model (
  input wire logic clk, // System clock
  input wire logic hready, // Bus ready seen by the master
  input wire logic [31:0] hrdata, // Read data from the slave
  output logic hsel, // Slave select
  output logic [31:0] haddr, // Byte address
  output logic [1:0] htrans, // Transfer type
  output logic hwrite, // Write when high
  output logic [2:0] hsize, // Always a word
  output logic [31:0] hwdata // Write data
);
  // Idle bus at time zero so nothing is taken during reset
  initial begin
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // One transfer; must be entered just after a rising edge.
  // Waits are unbounded here; the bench timeout cuts a hang.
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [7:0] d, output logic [7:0] q);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    // Reads get a changing pattern so stale data never matches
    hwdata <= w ? {24'h0, d} : ~hwdata;
    do @(posedge clk); while (hready !== 1'h1);
    q = hrdata[7:0];
  endtask
endmodule
`default_nettype wire

// *** sim/tb_cascaded_irq_status_poll_unit.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_cascaded_irq_status_poll_unit;
  typedef struct packed {
    logic [15:0] irq;
    logic [7:0] addr;
    logic wr;
    logic [7:0] data;
    logic intr;
  } cip_row_t;
  localparam int NROWS = 37;
  localparam int LIMIT = 3000;
  logic clk_sys, rst_n, hsel, hwrite, hready, hresp, int_out;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] irq_in;
  logic [7:0] q;
  int errors, checks_done, cycles;
  cip_row_t rows [NROWS];

  cip_host_model host (.clk(clk_sys), .hready(hready), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata));

  cip_status_poll_unit dut (.CLK_SYS(clk_sys), .RST_N(rst_n),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
    .HREADYOUT(hready), .HRESP(hresp), .IRQ_IN(irq_in),
    .INT_OUT(int_out));

  // ----------------------------------------------------------------
  // Clock, timeout and reporting
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'h0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Rows take 14 (write) or 15 (read) cycles each; the ceiling leaves ample margin
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == LIMIT) begin
      errors++;
      results();
    end
  end

  task automatic check(input string name, input logic [7:0] exp,
                       input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic results();
    if (errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Sequence: pins, bus operation, write data or read value, interrupt level
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'h0;
    irq_in = 16'h0;
    rows = '{
      '{16'h0000, 8'h00, 1'h0, 8'h00, 1'h0},
      '{16'h0000, 8'h04, 1'h1, 8'h00, 1'h0},
      '{16'h0000, 8'h0C, 1'h1, 8'h00, 1'h0},
      '{16'h0020, 8'h00, 1'h0, 8'h20, 1'h1},
      '{16'h0020, 8'h00, 1'h1, 8'h0B, 1'h1},
      '{16'h0020, 8'h00, 1'h0, 8'h00, 1'h1},
      '{16'h0020, 8'h00, 1'h1, 8'h0C, 1'h1},
      '{16'h0020, 8'h00, 1'h0, 8'h85, 1'h0},
      '{16'h0060, 8'h00, 1'h0, 8'h20, 1'h0},
      '{16'h0068, 8'h00, 1'h1, 8'h0A, 1'h1},
      '{16'h0068, 8'h00, 1'h0, 8'h48, 1'h1},
      '{16'h0028, 8'h00, 1'h0, 8'h48, 1'h1},
      '{16'h0028, 8'h00, 1'h1, 8'h0C, 1'h1},
      '{16'h0028, 8'h00, 1'h0, 8'h83, 1'h0},
      '{16'h0028, 8'h00, 1'h1, 8'h68, 1'h1},
      '{16'h0028, 8'h00, 1'h1, 8'h48, 1'h1},
      '{16'h0028, 8'h00, 1'h1, 8'h28, 1'h0},
      '{16'h0028, 8'h00, 1'h1, 8'h20, 1'h0},
      '{16'h0028, 8'h00, 1'h1, 8'h0B, 1'h0},
      '{16'h0028, 8'h00, 1'h0, 8'h20, 1'h0},
      '{16'h0028, 8'h00, 1'h1, 8'h65, 1'h1},
      '{16'h0028, 8'h00, 1'h1, 8'h0C, 1'h1},
      '{16'h0028, 8'h00, 1'h0, 8'h86, 1'h0},
      '{16'h0228, 8'h04, 1'h1, 8'h04, 1'h0},
      '{16'h0228, 8'h04, 1'h1, 8'h00, 1'h1},
      '{16'h0228, 8'h00, 1'h1, 8'h0C, 1'h1},
      '{16'h0228, 8'h00, 1'h0, 8'h82, 1'h0},
      '{16'h0228, 8'h08, 1'h1, 8'h0C, 1'h0},
      '{16'h0228, 8'h08, 1'h0, 8'h81, 1'h0},
      '{16'h0228, 8'h10, 1'h1, 8'hFF, 1'h0},
      '{16'h0228, 8'h10, 1'h0, 8'hF8, 1'h0},
      '{16'h0228, 8'h14, 1'h1, 8'hFF, 1'h0},
      '{16'h0228, 8'h14, 1'h0, 8'hDE, 1'h0},
      '{16'h0080, 8'h00, 1'h1, 8'h0A, 1'h0},
      '{16'h0080, 8'h00, 1'h0, 8'h80, 1'h0},
      '{16'h0000, 8'h00, 1'h0, 8'h00, 1'h0},
      '{16'h0000, 8'h20, 1'h0, 8'h00, 1'h0}};
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'h1;
    @(posedge clk_sys);
    // Settle pins past the two-flop synchroniser before each access
    foreach (rows[i]) begin
      irq_in <= rows[i].irq;
      repeat (6) @(posedge clk_sys);
      host.xfer(rows[i].addr, rows[i].wr, rows[i].data, q);
      if (!rows[i].wr) check("read data", rows[i].data, q);
      repeat (6) @(posedge clk_sys);
      check("int out", {7'h0, rows[i].intr}, {7'h0, int_out});
      check("resp", 8'h00, {7'h0, hresp});
    end
    // Mid-run reset while an edge request drives the output
    irq_in <= 16'h0081;
    repeat (8) @(posedge clk_sys);
    check("int before reset", 8'h01, {7'h0, int_out});
    rst_n <= 1'h0;
    // Pins drop in reset so the release sees no edge
    irq_in <= 16'h0000;
    @(posedge clk_sys);
    check("int in reset", 8'h00, {7'h0, int_out});
    rst_n <= 1'h1;
    repeat (6) @(posedge clk_sys);
    host.xfer(8'h10, 1'h0, 8'h00, q);
    check("edge level", 8'h00, q);
    host.xfer(8'h00, 1'h0, 8'h00, q);
    check("pending", 8'h00, q);
    irq_in <= 16'h0001;
    repeat (6) @(posedge clk_sys);
    host.xfer(8'h00, 1'h0, 8'h00, q);
    check("edge after reset", 8'h01, q);
    results();
  end
endmodule
`default_nettype wire
